// [dtc_timer_unit.sv]
// Dual timer/counter unit with prescalers, gating, four modes and interrupt flags
`timescale 1ns/10ps
`include "dtc_defs.svh"

module dtc_timer_unit (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // External pins
  input wire logic ext_irq_zero_pin,
  input wire logic ext_irq_one_pin,
  input wire logic first_count_pin,
  input wire logic second_count_pin,
  // Vectoring acknowledges
  input wire logic ack_ext_zero,
  input wire logic ack_first_ovf,
  input wire logic ack_ext_one,
  input wire logic ack_second_ovf,
  // Interrupt requests
  output logic ext_irq_zero_flag,
  output logic first_overflow_flag,
  output logic ext_irq_one_flag,
  output logic second_overflow_flag
);

  logic [1:0] mc_cnt_r;
  logic [5:0] presc_r;
  dtc_pkg::dtc_mode_reg_t mode_r;
  logic [7:0] ctl_r;
  logic [7:0] ctl_nxt;
  dtc_pkg::dtc_count_t first_r;
  dtc_pkg::dtc_count_t first_nxt;
  dtc_pkg::dtc_count_t second_r;
  dtc_pkg::dtc_count_t second_nxt;
  logic [3:0] samp_r;
  logic [1:0] pend_r;
  logic [1:0] pre_cnt_r [3];
  logic [7:0] rdata_r;

  logic mc_tick;
  logic [3:0] pins;
  logic [3:0] fall;
  logic [1:0] pre_sel [3];
  logic [2:0] pre_en;
  logic [2:0] pre_fire;
  logic [1:0] run_en;
  logic [1:0] tmr_inc;
  logic [1:0] tf_set;
  logic [1:0] ack_ext;
  logic [1:0] ack_tf;
  logic split;
  logic hi_inc;
  dtc_pkg::dtc_step_t step_first;
  dtc_pkg::dtc_step_t step_second;
  logic wr_presc;
  logic wr_mode;
  logic wr_ctl;
  logic wr_fl;
  logic wr_fh;
  logic wr_sl;
  logic wr_sh;
  logic [7:0] rd_mux;

  // One count step per mode
  function automatic dtc_pkg::dtc_step_t step(input logic [1:0] m, input dtc_pkg::dtc_count_t c);
    dtc_pkg::dtc_step_t r;
    r.ovf = 1'b0;
    r.cnt = c;
    unique case (m)
      `DTC_MODE_13: begin
        r.cnt.lo[4:0] = c.lo[4:0] + 5'h01;
        if (&c.lo[4:0]) begin
          r.cnt.hi = c.hi + 8'h01;
          r.ovf = &c.hi;
        end
      end
      `DTC_MODE_16: begin
        r.cnt = c + 16'h0001;
        r.ovf = &c;
      end
      `DTC_MODE_RELOAD: begin
        r.cnt.lo = (&c.lo) ? c.hi : c.lo + 8'h01;
        r.ovf = &c.lo;
      end
      `DTC_MODE_SPLIT: begin
        r.cnt.lo = c.lo + 8'h01;
        r.ovf = &c.lo;
      end
    endcase
    return r;
  endfunction

  // Machine cycle of three clocks
  assign mc_tick = (mc_cnt_r == `DTC_MC_LAST);
  assign pins = {second_count_pin, first_count_pin, ext_irq_one_pin, ext_irq_zero_pin};
  assign fall = mc_tick ? (samp_r & ~pins) : 4'h0;

  // Register decode
  assign wr_presc = reg_wr && (reg_addr == `DTC_ADDR_PRESCALE);
  assign wr_mode = reg_wr && (reg_addr == `DTC_ADDR_MODE);
  assign wr_ctl = reg_wr && (reg_addr == `DTC_ADDR_CONTROL);
  assign wr_fl = reg_wr && (reg_addr == `DTC_ADDR_FIRST_LOW);
  assign wr_fh = reg_wr && (reg_addr == `DTC_ADDR_FIRST_HIGH);
  assign wr_sl = reg_wr && (reg_addr == `DTC_ADDR_SECOND_LOW);
  assign wr_sh = reg_wr && (reg_addr == `DTC_ADDR_SECOND_HIGH);
  assign rd_mux = (reg_addr == `DTC_ADDR_PRESCALE) ? {2'h0, presc_r} :
                  (reg_addr == `DTC_ADDR_MODE) ? mode_r :
                  (reg_addr == `DTC_ADDR_CONTROL) ? ctl_r :
                  (reg_addr == `DTC_ADDR_FIRST_LOW) ? first_r.lo :
                  (reg_addr == `DTC_ADDR_FIRST_HIGH) ? first_r.hi :
                  (reg_addr == `DTC_ADDR_SECOND_LOW) ? second_r.lo :
                  (reg_addr == `DTC_ADDR_SECOND_HIGH) ? second_r.hi : 8'h00;

  // Run and gating
  assign split = ({mode_r.first.mode_sel_high, mode_r.first.mode_sel_low} == `DTC_MODE_SPLIT);
  assign run_en[0] = ctl_r[`DTC_TR_BIT0] && (!mode_r.first.gate || ext_irq_zero_pin);
  assign run_en[1] = ctl_r[`DTC_TR_BIT0 + `DTC_CHAN_STRIDE] && (!mode_r.second.gate || ext_irq_one_pin) &&
                     ({mode_r.second.mode_sel_high, mode_r.second.mode_sel_low} != `DTC_MODE_SPLIT);

  // Prescaler selects and enables
  assign pre_sel[0] = presc_r[`DTC_FIRST_PSEL_LSB +: 2];
  assign pre_sel[1] = presc_r[`DTC_SECOND_PSEL_LSB +: 2];
  assign pre_sel[2] = presc_r[`DTC_UPPER_PSEL_LSB +: 2];
  assign pre_en[0] = run_en[0] && !mode_r.first.counter_sel;
  assign pre_en[1] = run_en[1] && !mode_r.second.counter_sel;
  assign pre_en[2] = split && ctl_r[`DTC_TR_BIT0 + `DTC_CHAN_STRIDE];

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_pre
      assign pre_fire[gi] = mc_tick && pre_en[gi] && (pre_cnt_r[gi] == pre_sel[gi]);
      always_ff @(posedge clock) begin
        if (reset || !pre_en[gi]) begin
          pre_cnt_r[gi] <= 2'h0;
        end else if (mc_tick) begin
          pre_cnt_r[gi] <= pre_fire[gi] ? 2'h0 : pre_cnt_r[gi] + 2'h1;
        end
      end
    end
  endgenerate

  // Event counting is applied one machine cycle after the edge
  generate
    for (gi = 0; gi < 2; gi++) begin : g_evt
      always_ff @(posedge clock) begin
        if (reset) begin
          pend_r[gi] <= 1'b0;
        end else if (mc_tick) begin
          pend_r[gi] <= fall[2 + gi];
        end
      end
    end
  endgenerate

  assign tmr_inc[0] = mode_r.first.counter_sel ? (mc_tick && pend_r[0] && run_en[0]) : pre_fire[0];
  assign tmr_inc[1] = mode_r.second.counter_sel ? (mc_tick && pend_r[1] && run_en[1]) : pre_fire[1];
  assign hi_inc = pre_fire[2];

  assign step_first = step({mode_r.first.mode_sel_high, mode_r.first.mode_sel_low}, first_r);
  assign step_second = step({mode_r.second.mode_sel_high, mode_r.second.mode_sel_low}, second_r);

  assign tf_set[0] = tmr_inc[0] && step_first.ovf;
  assign tf_set[1] = split ? (hi_inc && (&first_r.hi)) : (tmr_inc[1] && step_second.ovf);
  assign ack_ext = {ack_ext_one, ack_ext_zero};
  assign ack_tf = {ack_second_ovf, ack_first_ovf};

  // Control register next value per channel
  generate
    for (gi = 0; gi < 2; gi++) begin : g_ctl
      localparam int TF = `DTC_TF_BIT0 + `DTC_CHAN_STRIDE * gi;
      localparam int TR = `DTC_TR_BIT0 + `DTC_CHAN_STRIDE * gi;
      localparam int IE = `DTC_IE_BIT0 + `DTC_CHAN_STRIDE * gi;
      localparam int IT = `DTC_IT_BIT0 + `DTC_CHAN_STRIDE * gi;
      assign ctl_nxt[TF] = tf_set[gi] || (wr_ctl ? reg_wdata[TF] : (ctl_r[TF] && !ack_tf[gi]));
      assign ctl_nxt[TR] = wr_ctl ? reg_wdata[TR] : ctl_r[TR];
      assign ctl_nxt[IT] = wr_ctl ? reg_wdata[IT] : ctl_r[IT];
      assign ctl_nxt[IE] = ctl_r[IT] ?
                           (fall[gi] || (wr_ctl ? reg_wdata[IE] : (ctl_r[IE] && !ack_ext[gi]))) :
                           !samp_r[gi];
    end
  endgenerate

  // Count register next values; software writes win over counting
  always_comb begin
    first_nxt = tmr_inc[0] ? step_first.cnt : first_r;
    if (split && hi_inc) begin
      first_nxt.hi = first_r.hi + 8'h01;
    end
    if (wr_fl) begin
      first_nxt.lo = reg_wdata;
    end
    if (wr_fh) begin
      first_nxt.hi = reg_wdata;
    end
    second_nxt = tmr_inc[1] ? step_second.cnt : second_r;
    if (wr_sl) begin
      second_nxt.lo = reg_wdata;
    end
    if (wr_sh) begin
      second_nxt.hi = reg_wdata;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      mc_cnt_r <= 2'h0;
      samp_r <= 4'hF;
    end else begin
      mc_cnt_r <= mc_tick ? 2'h0 : mc_cnt_r + 2'h1;
      samp_r <= mc_tick ? pins : samp_r;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      presc_r <= `DTC_PRESCALE_RST;
      mode_r <= `DTC_MODE_RST;
      ctl_r <= `DTC_CONTROL_RST;
    end else begin
      presc_r <= wr_presc ? reg_wdata[5:0] : presc_r;
      mode_r <= wr_mode ? reg_wdata : mode_r;
      ctl_r <= ctl_nxt;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      first_r <= {`DTC_COUNT_RST, `DTC_COUNT_RST};
      second_r <= {`DTC_COUNT_RST, `DTC_COUNT_RST};
      rdata_r <= 8'h00;
    end else begin
      first_r <= first_nxt;
      second_r <= second_nxt;
      rdata_r <= reg_rd ? rd_mux : 8'h00;
    end
  end

  assign reg_rdata = rdata_r;
  assign ext_irq_zero_flag = ctl_r[`DTC_IE_BIT0];
  assign first_overflow_flag = ctl_r[`DTC_TF_BIT0];
  assign ext_irq_one_flag = ctl_r[`DTC_IE_BIT0 + `DTC_CHAN_STRIDE];
  assign second_overflow_flag = ctl_r[`DTC_TF_BIT0 + `DTC_CHAN_STRIDE];

  // Checks
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (reset);

  sequence s_mc_gap;
    !mc_tick ##1 !mc_tick ##1 mc_tick;
  endsequence
  property p_mc_period;
    mc_tick |=> s_mc_gap;
  endproperty
  a_mc_period: assert property (p_mc_period) else $error("machine cycle not three clocks");

  property p_reset_presc;
    $fell(reset) |-> (presc_r == 6'h3F);
  endproperty
  a_reset_presc: assert property (p_reset_presc) else $error("prescale not slowest after reset");

  property p_timer_rate;
    (pre_fire[1] && pre_sel[1] == 2'h3 && $stable(pre_sel[1])) |->
      ($past(pre_en[1], 9) && !$past(pre_fire[1], 3) && !$past(pre_fire[1], 6) && !$past(pre_fire[1], 9));
  endproperty
  a_timer_rate: assert property (p_timer_rate) else $error("slowest rate fired early");

  sequence s_edge_seen;
    mc_tick && fall[2];
  endsequence
  property p_count_delay;
    s_edge_seen |=> pend_r[0] [*3];
  endproperty
  a_count_delay: assert property (p_count_delay) else $error("event not held until next cycle");

  property p_gate;
    tmr_inc[0] |-> (ctl_r[4] && (!mode_r.first.gate || ext_irq_zero_pin));
  endproperty
  a_gate: assert property (p_gate) else $error("first timer counted while gated off");

  property p_ovf16;
    (tmr_inc[0] && mode_r.first == 4'h1 && first_r == 16'hFFFF && !wr_fl && !wr_fh) |=>
      (first_overflow_flag && first_r == 16'h0000);
  endproperty
  a_ovf16: assert property (p_ovf16) else $error("16-bit rollover missed");

  property p_reload;
    (tmr_inc[0] && mode_r.first == 4'h2 && first_r.lo == 8'hFF && !wr_fl && !wr_fh) |=>
      (first_r.lo == $past(first_r.hi) && first_overflow_flag);
  endproperty
  a_reload: assert property (p_reload) else $error("reload from high byte missed");

  property p_second_stopped;
    (mode_r.second.mode_sel_high && mode_r.second.mode_sel_low && !wr_sl && !wr_sh) |=> $stable(second_r);
  endproperty
  a_second_stopped: assert property (p_second_stopped) else $error("second timer moved in mode 11");

  property p_split_flag;
    (split && hi_inc && first_r.hi == 8'hFF) |=> second_overflow_flag;
  endproperty
  a_split_flag: assert property (p_split_flag) else $error("split high byte did not set flag");

  property p_level;
    !ctl_r[0] ##1 !ctl_r[0] |-> (ext_irq_zero_flag == !$past(samp_r[0]));
  endproperty
  a_level: assert property (p_level) else $error("level flag not following source");

  property p_edge_set;
    (ctl_r[0] && fall[0]) |=> ext_irq_zero_flag;
  endproperty
  a_edge_set: assert property (p_edge_set) else $error("edge flag lost");

  property p_ack_clear;
    (first_overflow_flag && ack_first_ovf && !tf_set[0] && !wr_ctl) |=> !first_overflow_flag;
  endproperty
  a_ack_clear: assert property (p_ack_clear) else $error("overflow flag not cleared on vectoring");

  property p_mode13;
    (tmr_inc[0] && mode_r.first == 4'h0 && !wr_fl && !wr_fh) |=>
      (first_r.lo[7:5] == $past(first_r.lo[7:5]));
  endproperty
  a_mode13: assert property (p_mode13) else $error("mode 00 touched upper low bits");

  property p_rdata;
    !reg_rd |=> (reg_rdata == 8'h00);
  endproperty
  a_rdata: assert property (p_rdata) else $error("read data outside read slot");

endmodule

// [dtc_defs.svh]
// Register offsets, field positions, reset values and timing counts of the dual timer unit
`ifndef DTC_DEFS_SVH
`define DTC_DEFS_SVH

`define DTC_ADDR_PRESCALE 8'h00
`define DTC_ADDR_MODE 8'h01
`define DTC_ADDR_CONTROL 8'h02
`define DTC_ADDR_FIRST_LOW 8'h03
`define DTC_ADDR_FIRST_HIGH 8'h04
`define DTC_ADDR_SECOND_LOW 8'h05
`define DTC_ADDR_SECOND_HIGH 8'h06

`define DTC_PRESCALE_RST 6'h3F
`define DTC_MODE_RST 8'h00
`define DTC_CONTROL_RST 8'h00
`define DTC_COUNT_RST 8'h00

`define DTC_FIRST_PSEL_LSB 0
`define DTC_UPPER_PSEL_LSB 2
`define DTC_SECOND_PSEL_LSB 4

`define DTC_IT_BIT0 0
`define DTC_IE_BIT0 1
`define DTC_TR_BIT0 4
`define DTC_TF_BIT0 5
`define DTC_CHAN_STRIDE 2

`define DTC_MODE_13 2'h0
`define DTC_MODE_16 2'h1
`define DTC_MODE_RELOAD 2'h2
`define DTC_MODE_SPLIT 2'h3

`define DTC_MC_LAST 2'h2

`endif

// [dtc_pkg.sv]
// Types shared by the dual timer unit
package dtc_pkg;

  typedef struct packed {
    logic gate;
    logic counter_sel;
    logic mode_sel_high;
    logic mode_sel_low;
  } dtc_cfg_t;

  typedef struct packed {
    dtc_cfg_t second;
    dtc_cfg_t first;
  } dtc_mode_reg_t;

  typedef struct packed {
    logic [7:0] hi;
    logic [7:0] lo;
  } dtc_count_t;

  typedef struct packed {
    logic ovf;
    dtc_count_t cnt;
  } dtc_step_t;

endpackage

// [dtc_pin_model.sv]
// External count pin model producing falling-edge event bursts
`timescale 1ns/10ps
module dtc_pin_model (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Burst request
  input wire logic start,
  input wire logic slow,
  input wire logic [7:0] n_events,
  output logic busy,
  // Count pins
  output logic first_count_pin,
  output logic second_count_pin
);
  logic pin_lvl;
  int hold;
  assign first_count_pin = pin_lvl;
  assign second_count_pin = pin_lvl;
  // Pins idle high through the pull-up
  always begin
    @(posedge clock);
    if (reset) begin
      pin_lvl <= 1'b1;
      busy <= 1'b0;
    end else if (start) begin
      busy <= 1'b1;
      hold = slow ? 6 : 3; // Each level spans one machine cycle, or two when slow
      for (int i = 0; i < n_events; i++) begin
        pin_lvl <= 1'b0;
        repeat (hold) @(posedge clock);
        pin_lvl <= 1'b1;
        repeat (hold) @(posedge clock);
      end
      busy <= 1'b0;
    end
  end
endmodule

// [dtc_timer_unit_tb.sv]
// Self-checking bench for the dual timer unit
`timescale 1ns/10ps
`include "dtc_defs.svh"
module dtc_timer_unit_tb;
  localparam logic [7:0] A_PRE = `DTC_ADDR_PRESCALE;
  localparam logic [7:0] A_MODE = `DTC_ADDR_MODE;
  localparam logic [7:0] A_CTL = `DTC_ADDR_CONTROL;
  localparam logic [7:0] A_FL = `DTC_ADDR_FIRST_LOW;
  localparam logic [7:0] A_FH = `DTC_ADDR_FIRST_HIGH;
  localparam logic [7:0] A_SL = `DTC_ADDR_SECOND_LOW;
  logic clock, reset, reg_wr, reg_rd, irq0, irq1, m_start, m_slow, m_busy, p0, p1;
  logic ack_ez, ack_fo, ack_eo, ack_so, f_ez, f_fo, f_eo, f_so;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, m_n, va, vb, vc;
  int error_cnt = 0;
  int check_count = 0;
  int cycles = 0;
  int n;
  typedef struct {logic [7:0] pre, mode, ctl, addr; logic irq; int win; logic [7:0] delta;} dtc_row_t;
  dtc_row_t rows[11] = '{
    '{8'h3C, 8'h11, 8'h50, A_FL, 1'b1, 30, 8'h0A},
    '{8'h3D, 8'h11, 8'h50, A_FL, 1'b1, 60, 8'h0A},
    '{8'h3E, 8'h11, 8'h50, A_FL, 1'b1, 90, 8'h0A},
    '{8'h3F, 8'h11, 8'h50, A_FL, 1'b1, 120, 8'h0A},
    '{8'h0F, 8'h11, 8'h50, A_SL, 1'b1, 30, 8'h0A},
    '{8'h3C, 8'h99, 8'h50, A_FL, 1'b1, 30, 8'h0A},
    '{8'h3C, 8'h99, 8'h50, A_FL, 1'b0, 30, 8'h00},
    '{8'h3C, 8'h11, 8'h40, A_FL, 1'b1, 30, 8'h00},
    '{8'h33, 8'h13, 8'h40, A_FH, 1'b1, 30, 8'h0A},
    '{8'h0C, 8'h13, 8'h10, A_FL, 1'b1, 30, 8'h0A},
    '{8'h00, 8'h33, 8'h40, A_SL, 1'b1, 30, 8'h00}};

  dtc_timer_unit u_dtc_timer_unit (.clock(clock), .reset(reset), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ext_irq_zero_pin(irq0), .ext_irq_one_pin(irq1), .first_count_pin(p0), .second_count_pin(p1),
    .ack_ext_zero(ack_ez), .ack_first_ovf(ack_fo), .ack_ext_one(ack_eo), .ack_second_ovf(ack_so),
    .ext_irq_zero_flag(f_ez), .first_overflow_flag(f_fo), .ext_irq_one_flag(f_eo),
    .second_overflow_flag(f_so));
  dtc_pin_model u_dtc_pin_model (.clock(clock), .reset(reset), .start(m_start), .slow(m_slow),
    .n_events(m_n), .busy(m_busy), .first_count_pin(p0), .second_count_pin(p1));

  task automatic give_verdict;
    if (error_cnt == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: byte %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH at %0t: flag %b expected %b", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(negedge clock);
    d = reg_rdata;
  endtask
  task automatic ack(input logic [3:0] s);
    @(posedge clock);
    {ack_so, ack_eo, ack_fo, ack_ez} <= s;
    @(posedge clock);
    {ack_so, ack_eo, ack_fo, ack_ez} <= 4'h0;
    @(negedge clock);
  endtask
  // Count advance over a window of exactly win cycles
  task automatic meas(input logic [7:0] a, input int win, input logic [7:0] d);
    logic [7:0] x, y;
    rd(a, x);
    repeat (win - 2) @(posedge clock);
    rd(a, y);
    chk8(y - x, d);
  endtask
  task automatic wait_flag(input int s);
    n = 0;
    while ((s ? f_so : f_fo) !== 1'b1 && n < 40) begin
      @(negedge clock);
      n++;
    end
  endtask

  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles > 5000) begin
      error_cnt++;
      give_verdict();
    end
  end

  initial begin
    reset = 1'b1;
    {reg_wr, reg_rd, m_start, m_slow, ack_ez, ack_fo, ack_eo, ack_so} = 8'h00;
    {reg_addr, reg_wdata, m_n} = 24'h000000;
    {irq0, irq1} = 2'b11;
    repeat (4) @(posedge clock);
    reset <= 1'b0;
    for (int a = 0; a < 8; a++) begin
      rd(a[7:0], va);
      chk8(va, (a == 0) ? 8'h3F : 8'h00);
    end
    wr(A_PRE, 8'hFF);
    rd(A_PRE, va);
    chk8(va, 8'h3F);
    wr(A_MODE, 8'hA5);
    rd(A_MODE, va);
    chk8(va, 8'hA5);
    wr(A_CTL, 8'hA5);
    rd(A_CTL, va);
    chk8(va, 8'hA5);
    chk1(f_so & f_fo, 1'b1);
    foreach (rows[i]) begin
      wr(A_CTL, 8'h00);
      wr(A_PRE, rows[i].pre);
      wr(A_MODE, rows[i].mode);
      irq0 <= rows[i].irq;
      irq1 <= rows[i].irq;
      wr(A_CTL, rows[i].ctl);
      meas(rows[i].addr, rows[i].win, rows[i].delta);
    end
    irq0 <= 1'b1;
    irq1 <= 1'b1;
    // Overflow in modes 00, 01 and 10
    for (int m = 0; m < 3; m++) begin
      wr(A_CTL, 8'h00);
      wr(A_PRE, 8'h3D);
      wr(A_MODE, m[7:0]);
      wr(A_FL, (m == 0) ? 8'h1F : 8'hFF);
      wr(A_FH, (m == 2) ? 8'h80 : 8'hFF);
      wr(A_CTL, 8'h10);
      wait_flag(0);
      chk1(f_fo, 1'b1);
      wr(A_CTL, 8'h20);
      rd(A_FH, va);
      chk8(va, (m == 2) ? 8'h80 : 8'h00);
      rd(A_FL, va);
      chk8(va & ((m == 0) ? 8'h1F : 8'hFF), (m == 2) ? 8'h80 : 8'h00);
      ack(4'h2);
      chk1(f_fo, 1'b0);
    end
    // Split mode high byte drives the second flag
    wr(A_PRE, 8'h33);
    wr(A_MODE, 8'h03);
    wr(A_FH, 8'hFF);
    wr(A_CTL, 8'h40);
    wait_flag(1);
    chk1(f_so, 1'b1);
    chk1(f_fo, 1'b0);
    ack(4'h8);
    chk1(f_so, 1'b0);
    // Event counting, prompt and slow bursts
    wr(A_CTL, 8'h00);
    wr(A_MODE, 8'h55);
    wr(A_CTL, 8'h50);
    for (int s = 0; s < 2; s++) begin
      rd(A_FL, va);
      rd(A_SL, vb);
      @(posedge clock);
      m_slow <= s[0];
      m_n <= 8'h05;
      m_start <= 1'b1;
      @(posedge clock);
      m_start <= 1'b0;
      @(negedge clock);
      n = 0;
      while (m_busy !== 1'b0 && n < 100) begin
        @(negedge clock);
        n++;
      end
      repeat (6) @(posedge clock);
      rd(A_FL, vc);
      chk8(vc - va, 8'h05);
      rd(A_SL, vc);
      chk8(vc - vb, 8'h05);
    end
    // External interrupt flags, edge then level
    wr(A_CTL, 8'h05);
    irq0 <= 1'b0;
    irq1 <= 1'b0;
    repeat (6) @(posedge clock);
    @(negedge clock);
    chk1(f_ez & f_eo, 1'b1);
    ack(4'h1);
    chk1(f_ez, 1'b0);
    wr(A_CTL, 8'h05);
    @(negedge clock);
    chk1(f_eo, 1'b0);
    wr(A_CTL, 8'h00);
    repeat (6) @(posedge clock);
    @(negedge clock);
    chk1(f_ez, 1'b1);
    ack(4'h1);
    chk1(f_ez, 1'b1);
    @(posedge clock);
    irq0 <= 1'b1;
    irq1 <= 1'b1;
    repeat (6) @(posedge clock);
    @(negedge clock);
    chk1(f_ez | f_eo, 1'b0);
    give_verdict();
  end
endmodule
